// [rtl/clock_handshake_status_timing.sv]
// clock select, divider ready handshakes and power sequence controller
//
// Overview of operation
// - oscillator select status follows switch acknowledge within bound
// - vco bypass status follows bypass switch acknowledge within bound
// - p divider ready follows acknowledge, cleared on change
// - n divider ready follows acknowledge, cleared on change
// - first output divider ready follows its acknowledge
// - second output divider ready follows its acknowledge
// - disconnect flag set or cleared next cycle
// - trigger clears that sequence enable within two cycles
// - return to idle depends on analog wait
// - every power transition completes within 1000 us
// - digital part at most six steps of 67
// - analog ramp wait adds about 40 us
// - five cycles overhead plus three per step
`include "clk_hs_defines.svh"
module clock_handshake_status_timing #(
   parameter int ANALOG_CYC = `ANALOG_WAIT_CYC,
   parameter int TIMEOUT_CYC = `TRANSITION_MAX_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic osc_select_req,
   input wire logic vco_bypass_req,
   input wire logic osc_switched_ack,
   input wire logic bypass_switched_ack,
   input wire logic p_divider_ack,
   input wire logic n_divider_ack,
   input wire logic out_div1_ack,
   input wire logic out_div2_ack,
   input wire logic [3:0] divider_changed,
   input wire logic [3:0] pll_div_done,
   input wire logic set_input_disconnect,
   input wire logic clear_input_disconnect,
   input wire logic [1:0] sequence_trigger,
   input wire logic [1:0] sequence_enable_set,
   input wire clk_hs_pkg::seq_profile_type seq_profile_a,
   input wire clk_hs_pkg::seq_profile_type seq_profile_b,
   input wire logic analog_power_good,
   output clk_hs_pkg::pll_status_type pll_status_reg,
   output logic osc_select_drive,
   output logic vco_bypass_drive,
   output logic [3:0] div_accept,
   output logic input_disconnect_req,
   output logic [1:0] sequence_enable,
   output logic [1:0] sequence_active_flag,
   output logic power_state_machine_status,
   output logic [2:0] step_strobe_count,
   output logic transition_timeout
);

   // refuse counts that would leave the counters without a bit
   if (ANALOG_CYC < 1 || TIMEOUT_CYC < 1) begin : g_bad_param
      $error("analog and time-out counts must be positive");
   end

   localparam int TCW = $clog2(TIMEOUT_CYC + 1);
   localparam int ACW = $clog2(ANALOG_CYC + 1);

   // cross-domain feedback from the pll and clock switch
   logic osc_sw_s;
   logic byp_sw_s;
   logic [3:0] div_done_s;
   logic ana_good_s;

   flag_sync u_sync_osc (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(osc_switched_ack),
      .sync_out(osc_sw_s)
   );

   flag_sync u_sync_byp (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(bypass_switched_ack),
      .sync_out(byp_sw_s)
   );

   flag_sync u_sync_ana (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(analog_power_good),
      .sync_out(ana_good_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_div
         flag_sync u_sync_div (
            .clk(clk),
            .reset_n(reset_n),
            .async_in(pll_div_done[gi]),
            .sync_out(div_done_s[gi])
         );
      end
   endgenerate

   // select and bypass requests go out registered; status tracks the
   // switch's handshake, so the bound is two slow clocks plus sync
   logic osc_drive_r;
   logic byp_drive_r;
   logic osc_st_r;
   logic byp_st_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_drive_r <= 1'b0;
         byp_drive_r <= 1'b0;
         osc_st_r <= 1'b0;
         byp_st_r <= 1'b0;
      end else begin
         osc_drive_r <= osc_select_req;
         byp_drive_r <= vco_bypass_req;
         osc_st_r <= osc_sw_s;
         byp_st_r <= byp_sw_s;
      end
   end

   assign osc_select_drive = osc_drive_r;
   assign vco_bypass_drive = byp_drive_r;

   // divider handshakes: accept is the ack level sent to the pll, ready
   // rises when the pll has taken the value and drops once ack is low and
   // the divider was changed; a change with ack high is ignored
   logic [3:0] acks;
   logic [3:0] rdy_r;
   logic [3:0] changed_r;
   logic [3:0] accept_r;

   assign acks = {out_div2_ack, out_div1_ack, n_divider_ack, p_divider_ack};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_r <= 4'h0;
         changed_r <= 4'h0;
         accept_r <= 4'h0;
      end else begin
         accept_r <= acks;
         changed_r <= (changed_r | (divider_changed & ~acks)) & ~acks;
         for (int i = 0; i < 4; i++) begin
            if (accept_r[i] && div_done_s[i]) begin
               rdy_r[i] <= 1'b1;
            end else if (!acks[i] && (changed_r[i] || divider_changed[i])) begin
               rdy_r[i] <= 1'b0;
            end
         end
      end
   end

   assign div_accept = accept_r;

   // disconnect flag mirrors the request line; set wins over clear
   logic disc_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         disc_r <= 1'b0;
      end else if (set_input_disconnect) begin
         disc_r <= 1'b1;
      end else if (clear_input_disconnect) begin
         disc_r <= 1'b0;
      end
   end

   assign input_disconnect_req = disc_r;

   assign pll_status_reg = '{osc_select_status: osc_st_r,
                             vco_bypass_status: byp_st_r,
                             p_divider_ready: rdy_r[0],
                             n_divider_ready: rdy_r[1],
                             out_div1_ready: rdy_r[2],
                             out_div2_ready: rdy_r[3],
                             input_disconnect_status: disc_r};

   // power sequence controller
   clk_hs_pkg::psm_state_type state_r;
   clk_hs_pkg::seq_profile_type prof_r;
   logic [1:0] en_r;
   logic [1:0] act_r;
   logic [2:0] step_r;
   logic [6:0] cnt_r;
   logic [ACW-1:0] ana_cnt_r;
   logic [TCW-1:0] to_cnt_r;
   logic to_r;
   logic [1:0] fire;
   logic [5:0] steps_clip;

   // a trigger only starts its sequence if enabled; on a tie a starts and b does not, though its enable is still cleared
   assign fire = sequence_trigger & en_r &
                 {2{state_r == clk_hs_pkg::psm_idle}};
   assign steps_clip = (prof_r.steps > 6'(`PSM_MAX_STEPS)) ?
                       6'(`PSM_MAX_STEPS) : prof_r.steps;

   // enables: hardware clear on start beats a software set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         en_r <= 2'h0;
      end else begin
         en_r <= (en_r | sequence_enable_set) & ~fire;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= clk_hs_pkg::psm_idle;
         prof_r <= '0;
         act_r <= 2'h0;
         step_r <= 3'h0;
         cnt_r <= 7'h0;
         ana_cnt_r <= '0;
      end else begin
         case (state_r)
            clk_hs_pkg::psm_idle: begin
               if (fire[0]) begin
                  prof_r <= seq_profile_a;
                  act_r <= 2'h1;
                  state_r <= clk_hs_pkg::psm_start;
                  cnt_r <= 7'(`PSM_OVERHEAD_CYC - 2);
               end else if (fire[1]) begin
                  prof_r <= seq_profile_b;
                  act_r <= 2'h2;
                  state_r <= clk_hs_pkg::psm_start;
                  cnt_r <= 7'(`PSM_OVERHEAD_CYC - 2);
               end
            end
            clk_hs_pkg::psm_start: begin
               step_r <= 3'h0;
               if (cnt_r != 7'h0) begin
                  cnt_r <= cnt_r - 7'h1;
               end else if (steps_clip == 6'h0) begin
                  state_r <= clk_hs_pkg::psm_finish;
               end else begin
                  // the wait state's decision cycle is the third overhead
                  cnt_r <= 7'(`PSM_STEP_OVERHEAD_CYC - 2);
                  state_r <= clk_hs_pkg::psm_step_head;
               end
            end
            clk_hs_pkg::psm_step_head: begin
               if (cnt_r != 7'h0) begin
                  cnt_r <= cnt_r - 7'h1;
               end else begin
                  cnt_r <= (prof_r.step_wait > 7'(`PSM_DIGITAL_WAIT_CYC)) ?
                           7'(`PSM_DIGITAL_WAIT_CYC) : prof_r.step_wait;
                  state_r <= clk_hs_pkg::psm_step_wait;
               end
            end
            clk_hs_pkg::psm_step_wait: begin
               if (cnt_r != 7'h0) begin
                  cnt_r <= cnt_r - 7'h1;
               end else if (step_r == 3'h0 && prof_r.analog_wait) begin
                  ana_cnt_r <= ACW'(ANALOG_CYC);
                  state_r <= clk_hs_pkg::psm_analog;
               end else if ({3'h0, step_r} + 6'h1 >= steps_clip) begin
                  state_r <= clk_hs_pkg::psm_finish;
               end else begin
                  step_r <= step_r + 3'h1;
                  cnt_r <= 7'(`PSM_STEP_OVERHEAD_CYC - 2);
                  state_r <= clk_hs_pkg::psm_step_head;
               end
            end
            clk_hs_pkg::psm_analog: begin
               // ends on power good or the ramp budget, whichever first
               if (ana_good_s || ana_cnt_r == '0) begin
                  prof_r.analog_wait <= 1'b0;
                  state_r <= clk_hs_pkg::psm_step_wait;
               end else begin
                  ana_cnt_r <= ana_cnt_r - ACW'(1);
               end
            end
            clk_hs_pkg::psm_finish: begin
               act_r <= 2'h0;
               state_r <= clk_hs_pkg::psm_idle;
            end
            default: state_r <= clk_hs_pkg::psm_idle;
         endcase
      end
   end

   // watchdog on a running transition; flags an overrun, sticky to reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         to_cnt_r <= '0;
         to_r <= 1'b0;
      end else if (act_r == 2'h0) begin
         to_cnt_r <= '0;
      end else if (to_cnt_r >= TCW'(TIMEOUT_CYC)) begin
         to_r <= 1'b1;
      end else begin
         to_cnt_r <= to_cnt_r + TCW'(1);
      end
   end

   assign sequence_enable = en_r;
   assign sequence_active_flag = act_r;
   assign power_state_machine_status = (state_r != clk_hs_pkg::psm_idle);
   assign step_strobe_count = step_r;
   assign transition_timeout = to_r;

endmodule

// [rtl/clk_hs_defines.svh]
// timing constants and encodings for the clock handshake and status block
`ifndef CLK_HS_DEFINES_SVH
`define CLK_HS_DEFINES_SVH

`define CLK_FREQ_MHZ 25
`define SYNC_STAGES 3
`define FLAG_DELAY_SYS 2
`define SEQ_EN_CLEAR_CYC 2
`define PSM_OVERHEAD_CYC 5
`define PSM_STEP_OVERHEAD_CYC 3
`define PSM_MAX_STEPS 6
`define PSM_STEP_MAX_CYC 67
`define PSM_DIGITAL_WAIT_CYC 64
`define ANALOG_WAIT_US 40
`define ANALOG_WAIT_CYC (`ANALOG_WAIT_US * `CLK_FREQ_MHZ)
`define TRANSITION_MAX_US 1000
`define TRANSITION_MAX_CYC (`TRANSITION_MAX_US * `CLK_FREQ_MHZ)

`endif

// [rtl/clk_hs_pkg.sv]
// types for the clock handshake and power sequence block
package clk_hs_pkg;

   typedef enum logic [1:0] {
      div_p,
      div_n,
      div_k1,
      div_k2
   } div_sel_type;

   typedef struct packed {
      logic osc_select_status;
      logic vco_bypass_status;
      logic p_divider_ready;
      logic n_divider_ready;
      logic out_div1_ready;
      logic out_div2_ready;
      logic input_disconnect_status;
   } pll_status_type;

   typedef struct packed {
      logic [5:0] steps;
      logic [6:0] step_wait;
      logic analog_wait;
   } seq_profile_type;

   typedef enum {
      psm_idle,
      psm_start,
      psm_step_head,
      psm_step_wait,
      psm_analog,
      psm_finish
   } psm_state_type;

endpackage

// [rtl/flag_sync.sv]
// three-stage synchroniser with agreement filter for a level from another clock
module flag_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic async_in,
   output logic sync_out
);

   logic [2:0] stage_r;
   logic out_r;

   // first stage feeds only the second; out changes when stages two and three agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_r <= 3'h0;
         out_r <= 1'b0;
      end else begin
         stage_r <= {stage_r[1:0], async_in};
         if (stage_r[1] == stage_r[2]) begin
            out_r <= stage_r[2];
         end
      end
   end

   assign sync_out = out_r;

endmodule

// [verification/clock_handshake_status_timing_asserts.sv]
// port checker for the clock handshake and power sequence block
module clock_handshake_status_timing_asserts #(
   parameter int ANALOG_CYC = 1000
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic osc_switched_ack,
   input wire logic bypass_switched_ack,
   input wire logic p_divider_ack,
   input wire logic n_divider_ack,
   input wire logic [3:0] divider_changed,
   input wire logic [3:0] pll_div_done,
   input wire logic set_input_disconnect,
   input wire logic clear_input_disconnect,
   input wire logic [1:0] sequence_trigger,
   input wire logic [1:0] sequence_enable,
   input wire clk_hs_pkg::pll_status_type pll_status_reg,
   input wire logic input_disconnect_req,
   input wire logic power_state_machine_status,
   input wire logic transition_timeout
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] busy_cnt_r;
   // length of the running transition; a hang shows up as a large count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) busy_cnt_r <= 16'h0000;
      else if (power_state_machine_status) busy_cnt_r <= busy_cnt_r + 16'h0001;
      else busy_cnt_r <= 16'h0000;
   end
   chk_disc_set:
   assert property (set_input_disconnect |=> input_disconnect_req &&
      pll_status_reg.input_disconnect_status) else $error("disc not set");
   chk_disc_clear:
   assert property (clear_input_disconnect && !set_input_disconnect |=>
      !pll_status_reg.input_disconnect_status) else $error("disc not clear");
   chk_enable_clear:
   assert property (sequence_trigger[0] && sequence_enable[0] &&
      !power_state_machine_status |-> ##[1:2] !sequence_enable[0])
      else $error("enable not cleared");
   chk_osc_follow:
   assert property ($stable(osc_switched_ack) [*6] |->
      pll_status_reg.osc_select_status == osc_switched_ack)
      else $error("osc status late");
   chk_bypass_follow:
   assert property ($stable(bypass_switched_ack) [*6] |->
      pll_status_reg.vco_bypass_status == bypass_switched_ack)
      else $error("bypass status late");
   chk_pready_set:
   assert property ((p_divider_ack && pll_div_done[0]) [*7] |->
      pll_status_reg.p_divider_ready) else $error("p ready late");
   chk_nready_clear:
   assert property ((!n_divider_ack && divider_changed[1]) ##1
      (!n_divider_ack [*6]) |-> !pll_status_reg.n_divider_ready)
      else $error("n ready not cleared");
   chk_busy_bound:
   assert property (busy_cnt_r <= 410 + ANALOG_CYC) else $error("too long");
   chk_no_timeout:
   assert property (!transition_timeout) else $error("timeout raised");
   cover property (sequence_trigger[1] && sequence_enable[1]);
   cover property ($rose(pll_status_reg.out_div2_ready));
   cover property (set_input_disconnect && clear_input_disconnect);
endmodule

bind clock_handshake_status_timing clock_handshake_status_timing_asserts
   #(.ANALOG_CYC(ANALOG_CYC)) i_chk (.clk(clk), .reset_n(reset_n),
   .osc_switched_ack(osc_switched_ack),
   .bypass_switched_ack(bypass_switched_ack),
   .p_divider_ack(p_divider_ack), .n_divider_ack(n_divider_ack),
   .divider_changed(divider_changed), .pll_div_done(pll_div_done),
   .set_input_disconnect(set_input_disconnect),
   .clear_input_disconnect(clear_input_disconnect),
   .sequence_trigger(sequence_trigger), .sequence_enable(sequence_enable),
   .pll_status_reg(pll_status_reg),
   .input_disconnect_req(input_disconnect_req),
   .power_state_machine_status(power_state_machine_status),
   .transition_timeout(transition_timeout));

// [verification/tb_clock_handshake_status_timing.sv]
// self-checking bench for the clock handshake and power sequence block
module tb_clock_handshake_status_timing;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ACYC = 20;
   logic clk, reset_n, osc_req, byp_req, osc_ack, byp_ack, apg, sdis, cdis;
   logic [3:0] ack_v, chg, done, acc;
   logic [1:0] trg, ens, en, act;
   clk_hs_pkg::seq_profile_type pa, pb;
   clk_hs_pkg::pll_status_type st;
   logic osc_drv, byp_drv, dis_req, busy, tmo;
   logic [2:0] stp;
   int bad_count, checks;

   clock_handshake_status_timing #(.ANALOG_CYC(ACYC), .TIMEOUT_CYC(500))
   i_dut (.clk(clk), .reset_n(reset_n), .osc_select_req(osc_req),
      .vco_bypass_req(byp_req), .osc_switched_ack(osc_ack),
      .bypass_switched_ack(byp_ack), .p_divider_ack(ack_v[0]),
      .n_divider_ack(ack_v[1]), .out_div1_ack(ack_v[2]),
      .out_div2_ack(ack_v[3]), .divider_changed(chg), .pll_div_done(done),
      .set_input_disconnect(sdis), .clear_input_disconnect(cdis),
      .sequence_trigger(trg), .sequence_enable_set(ens),
      .seq_profile_a(pa), .seq_profile_b(pb), .analog_power_good(apg),
      .pll_status_reg(st), .osc_select_drive(osc_drv),
      .vco_bypass_drive(byp_drv), .div_accept(acc),
      .input_disconnect_req(dis_req), .sequence_enable(en),
      .sequence_active_flag(act), .power_state_machine_status(busy),
      .step_strobe_count(stp), .transition_timeout(tmo));

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // bounded poll of one status bit; giving up ends the run
   task automatic wait_st(int b, logic v, string what);
      int n;
      n = 0;
      while (st[b] !== v && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(what, v, st[b]);
      if (st[b] !== v) final_report();
   endtask

   task automatic t_disconnect();
      @(posedge clk) sdis <= 1'b1;
      @(posedge clk) sdis <= 1'b0;
      #1 chk("disc set", 1, st.input_disconnect_status);
      @(posedge clk) {sdis, cdis} <= 2'h3;
      @(posedge clk) {sdis, cdis} <= 2'h0;
      #1 chk("disc both", 1, dis_req);
      @(posedge clk) cdis <= 1'b1;
      @(posedge clk) cdis <= 1'b0;
      #1 chk("disc clear", 0, {dis_req, st.input_disconnect_status});
      $display("test disconnect done");
   endtask

   task automatic t_clock_sel(logic v);
      @(posedge clk) {osc_req, osc_ack, byp_req, byp_ack} <= {4{v}};
      wait_st(6, v, "osc status");
      wait_st(5, v, "bypass status");
      chk("drives", {2{v}}, {osc_drv, byp_drv});
      $display("test clock select done");
   endtask

   task automatic t_dividers();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) {ack_v[i], done[i]} <= 2'h3;
         wait_st(4 - i, 1'b1, "ready set");
         chk("accept", 1, acc[i]);
         // a change while acknowledge is high must not drop ready
         @(posedge clk) chg[i] <= 1'b1;
         @(posedge clk) chg[i] <= 1'b0;
         repeat (6) @(posedge clk);
         #1 chk("ready kept", 1, st[4 - i]);
         @(posedge clk) ack_v[i] <= 1'b0;
         @(posedge clk) {chg[i], done[i]} <= 2'h2;
         @(posedge clk) chg[i] <= 1'b0;
         wait_st(4 - i, 1'b0, "ready clear");
      end
      $display("test dividers done");
   endtask

   task automatic run_seq(int s, output int dur);
      @(posedge clk) ens[s] <= 1'b1;
      @(posedge clk) {ens[s], trg[s]} <= 2'h1;
      @(posedge clk) trg[s] <= 1'b0;
      @(posedge clk);
      #1 chk("enable cleared", 0, en[s]);
      chk("active", 2'h1 << s, act);
      dur = 2;
      if (s == 0) begin
         // a second trigger while busy is refused and keeps its enable
         @(posedge clk) ens[1] <= 1'b1;
         @(posedge clk) {ens[1], trg[1]} <= 2'h1;
         @(posedge clk) trg[1] <= 1'b0;
         #1 chk("busy refused", 2'h1, act);
         chk("enable kept", 1, en[1]);
         dur = 5;
      end
      while (busy === 1'b1 && dur < 2000) begin
         @(posedge clk);
         #1;
         dur++;
      end
      chk("idle", 0, busy);
      if (busy !== 1'b0) final_report();
      repeat (2) @(posedge clk);
      #1 chk("active off", 0, act);
   endtask

   task automatic t_sequence();
      int da, db, dg;
      // a trigger without enable is refused
      @(posedge clk) trg[0] <= 1'b1;
      @(posedge clk) trg[0] <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("refused", 0, busy);
      run_seq(0, da);
      chk("last step", 5, stp);
      run_seq(1, db);
      chk("short len", 5 + 1 * 3, db - 1);
      chk("budget b", 1, db - 1 <= 5 + 3 + 64);
      chk("long min", 1, da >= 6 * 64 + ACYC);
      chk("long max", 1, da <= 5 + 6 * 67 + ACYC + 4);
      chk("short max", 1, db <= 12);
      chk("analog longer", 1, db < da);
      chk("timeout", 0, tmo);
      // power good ends the analog wait before the ramp budget runs out
      @(posedge clk) apg <= 1'b1;
      run_seq(0, dg);
      chk("good ends wait", 1, dg + ACYC <= da);
      $display("test sequence done");
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      reset_n = 1'b0;
      {osc_req, byp_req, osc_ack, byp_ack, apg, sdis, cdis} = 7'h00;
      {ack_v, chg, done, trg, ens} = 16'h0000;
      pa = '{steps: 6'h06, step_wait: 7'h40, analog_wait: 1'b1};
      pb = '{steps: 6'h01, step_wait: 7'h00, analog_wait: 1'b0};
      bad_count = 0;
      checks = 0;
      repeat (16) @(posedge clk);
      chk("reset status", 0, st);
      reset_n <= 1'b1;
      t_disconnect();
      t_clock_sel(1'b1);
      t_clock_sel(1'b0);
      t_dividers();
      t_sequence();
      final_report();
   end
endmodule
